// File: hdl/sdcs_pkg.sv
// Commands and decoding for the decoder end; modes shared by both ends
package sdcs_pkg;

  localparam int NUM_BANKS = 4;
  localparam int BANK_W    = 2;

  // Reset values
  localparam logic RST_CLOCK_GATE = 1'b1;

  typedef enum logic [3:0] {
    CMD_DESEL = 4'h0,
    CMD_NOP   = 4'h1,
    CMD_ACT   = 4'h2,
    CMD_READ  = 4'h3,
    CMD_WRITE = 4'h4,
    CMD_PRE   = 4'h5,
    CMD_MRS   = 4'h6,
    CMD_BST   = 4'h7,
    CMD_REF   = 4'h8
  } sdcs_cmd_t;

  typedef enum logic [1:0] {
    MODE_RUN     = 2'h0,
    MODE_SUSPEND = 2'h1,
    MODE_PDOWN   = 2'h2,
    MODE_SREF    = 2'h3
  } sdcs_mode_t;

  // Requests at the controller's user side
  typedef enum logic [3:0] {
    OP_NOP     = 4'h0,
    OP_ACT     = 4'h1,
    OP_READ    = 4'h2,
    OP_WRITE   = 4'h3,
    OP_PRE     = 4'h4,
    OP_PREALL  = 4'h5,
    OP_MRS     = 4'h6,
    OP_BST     = 4'h7,
    OP_REF     = 4'h8,
    OP_SREF    = 4'h9,
    OP_PDOWN   = 4'ha,
    OP_SUSPEND = 4'hb,
    OP_WAKE    = 4'hc
  } sdcs_op_t;

  function automatic sdcs_cmd_t sdcs_decode(input logic cs_n, input logic ras_n,
                                            input logic cas_n, input logic we_n);
    sdcs_cmd_t c;
    c = CMD_NOP;
    if (cs_n) begin
      c = CMD_DESEL;
    end else begin
      unique case ({ras_n, cas_n, we_n})
        3'h3: c = CMD_ACT;
        3'h5: c = CMD_READ;
        3'h4: c = CMD_WRITE;
        3'h2: c = CMD_PRE;
        3'h0: c = CMD_MRS;
        3'h7: c = CMD_NOP;
        3'h6: c = CMD_BST;
        3'h1: c = CMD_REF;
      endcase
    end
    return c;
  endfunction

  // Strobes legal on the edge that leaves a sleep mode
  function automatic logic sdcs_wake_ok(input logic cs_n, input logic ras_n,
                                        input logic cas_n);
    return cs_n | (ras_n & cas_n);
  endfunction

endpackage

// File: hdl/sdcs_if.sv
// Command pins from controller to decoder
`timescale 1ns/1ns
`default_nettype none
interface sdcs_if;
  logic                        chip_select_n;
  logic                        row_strobe_n;
  logic                        column_strobe_n;
  logic                        write_strobe_n;
  logic                        clock_gate;
  logic [sdcs_pkg::BANK_W-1:0] bank_select_bits;
  logic                        precharge_flag_bit;

  modport ctrl (
    output chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n,
    output clock_gate, bank_select_bits, precharge_flag_bit
  );
  modport dev (
    input chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n,
    input clock_gate, bank_select_bits, precharge_flag_bit
  );
endinterface
`default_nettype wire

// File: hdl/sdcs_device.sv
// Command decoder with power down, self refresh and clock suspend
// Function
// R1 - Sample command pins only at rising edge
// R2 - Decode activate, read, write, auto-precharge flag
// R3 - Activate/mode set idle; read/write active bank
// R4 - Precharge one bank or all banks
// R5 - Decode mode set, no-operation, deselect
// R6 - Burst stop only during full-page burst
// R7 - Idle refresh strobes: auto or self refresh
// R8 - Leave self refresh on clock gate rise
// R9 - Idle clock gate edges enter/exit power down
// R10 - Power down during burst becomes clock suspend
// R11 - Qualify commands with current and previous gate
// R12 - Controller keeps clock gate high for accesses
// R13 - Gate low with active bank: clock suspend
// R14 - Suspend freezes internal clock and burst
// R15 - Suspend takes effect one cycle after low
// R16 - Ignore all commands while suspended
// R17 - Resume one cycle after gate registered high
`timescale 1ns/1ns
`default_nettype none
module sdcs_device #(
  parameter int BURST_LEN = 8,
  parameter bit FULL_PAGE = 1'b0
) (
  input  wire logic                           CLK,
  input  wire logic                           RST_N,
  sdcs_if.dev                                 bus,
  output var  sdcs_pkg::sdcs_mode_t           MODE,
  output logic [sdcs_pkg::NUM_BANKS-1:0]      BANK_OPEN,
  output logic                                BURST_BUSY,
  output logic                                CLK_RUN,
  output logic                                CMD_VALID,
  output var  sdcs_pkg::sdcs_cmd_t            CMD,
  output logic [sdcs_pkg::BANK_W-1:0]         CMD_BANK,
  output logic                                CMD_AP,
  output logic                                PROTO_ERR
);

  localparam int CNT_W = $clog2(BURST_LEN + 1);
  localparam logic [CNT_W-1:0] BL_LOAD = CNT_W'(BURST_LEN);
  localparam logic [CNT_W-1:0] ONE     = CNT_W'(1);

  ////////////////////////////////////////////////////////////////////////////
  // State

  sdcs_pkg::sdcs_mode_t              mode, next_mode;
  logic                              clock_gate_prev, next_clock_gate_prev;
  logic [sdcs_pkg::NUM_BANKS-1:0]    bank_open, next_bank_open;
  logic [CNT_W-1:0]                  burst_left, next_burst_left;
  logic [sdcs_pkg::BANK_W-1:0]       burst_bank, next_burst_bank;
  logic                              burst_ap, next_burst_ap;
  logic                              burst_busy, next_burst_busy;
  logic                              clk_run, next_clk_run;
  logic                              cmd_valid, next_cmd_valid;
  sdcs_pkg::sdcs_cmd_t               cmd_q, next_cmd_q;
  logic [sdcs_pkg::BANK_W-1:0]       cmd_bank, next_cmd_bank;
  logic                              cmd_ap, next_cmd_ap;
  logic                              proto_err, next_proto_err;

  sdcs_pkg::sdcs_cmd_t               cmd;
  logic [sdcs_pkg::BANK_W-1:0]       bank;
  logic                              frozen;
  logic                              any_open;
  logic                              wake_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    cmd     = sdcs_pkg::sdcs_decode(bus.chip_select_n, bus.row_strobe_n,
                                    bus.column_strobe_n, bus.write_strobe_n); // [R1] [R2] [R5]
    bank    = bus.bank_select_bits;
    wake_ok = sdcs_pkg::sdcs_wake_ok(bus.chip_select_n, bus.row_strobe_n,
                                     bus.column_strobe_n);
    any_open = |bank_open;
    // Entry edge still runs; frozen from the next edge
    frozen  = (mode == sdcs_pkg::MODE_SUSPEND) && !clock_gate_prev; // [R14] [R15] [R17]

    next_mode            = mode;
    next_clock_gate_prev = bus.clock_gate; // [R11]
    next_bank_open       = bank_open;
    next_burst_left      = burst_left;
    next_burst_bank      = burst_bank;
    next_burst_ap        = burst_ap;
    next_cmd_valid       = 1'b0;
    next_cmd_q           = cmd_q;
    next_cmd_bank        = cmd_bank;
    next_cmd_ap          = cmd_ap;
    next_proto_err       = 1'b0;

    // A full-page burst runs until stopped or precharged
    if (!frozen && burst_busy && !FULL_PAGE) begin // [R14]
      next_burst_left = burst_left - ONE;
      if (burst_left == ONE && burst_ap) begin
        next_bank_open[burst_bank] = 1'b0;
      end
    end

    unique case (mode)
      sdcs_pkg::MODE_RUN: begin
        if (clock_gate_prev) begin // [R11]
          next_cmd_q    = cmd;
          next_cmd_bank = bank;
          next_cmd_ap   = bus.precharge_flag_bit;
          unique case (cmd)
            sdcs_pkg::CMD_ACT: begin
              next_cmd_valid = 1'b1;
              if (bank_open[bank]) begin
                next_proto_err = 1'b1; // [R3]
              end else begin
                next_bank_open[bank] = 1'b1; // [R2]
              end
            end
            sdcs_pkg::CMD_READ, sdcs_pkg::CMD_WRITE: begin
              next_cmd_valid = 1'b1;
              if (!bank_open[bank] || (FULL_PAGE && bus.precharge_flag_bit)) begin
                next_proto_err = 1'b1; // [R3]
              end else begin
                // A new access cuts the running burst short
                next_burst_left = BL_LOAD;
                next_burst_bank = bank;
                next_burst_ap   = bus.precharge_flag_bit; // [R2]
              end
            end
            sdcs_pkg::CMD_PRE: begin
              next_cmd_valid = 1'b1;
              if (bus.precharge_flag_bit) begin
                next_bank_open = '0; // [R4]
                next_burst_left = '0;
              end else begin
                next_bank_open[bank] = 1'b0; // [R4]
                if (bank == burst_bank) begin
                  next_burst_left = '0;
                end
              end
            end
            sdcs_pkg::CMD_MRS: begin
              next_cmd_valid = 1'b1;
              next_proto_err = any_open; // [R3] [R5]
            end
            sdcs_pkg::CMD_BST: begin
              next_cmd_valid = 1'b1;
              if (FULL_PAGE && burst_busy) begin
                next_burst_left = '0;
              end else begin
                next_proto_err = 1'b1; // [R6]
              end
            end
            sdcs_pkg::CMD_REF: begin
              // Gate falling: self refresh instead, or suspend with a bank open or a burst running
              if (bus.clock_gate) begin
                next_cmd_valid = 1'b1;
                next_proto_err = any_open; // [R7]
              end
            end
            sdcs_pkg::CMD_NOP, sdcs_pkg::CMD_DESEL: begin
            end
          endcase
        end
        if (clock_gate_prev && !bus.clock_gate) begin
          if (any_open || burst_busy) begin
            next_mode = sdcs_pkg::MODE_SUSPEND; // [R13] [R10]
          end else if (cmd == sdcs_pkg::CMD_REF) begin
            next_mode = sdcs_pkg::MODE_SREF; // [R7]
          end else if (cmd == sdcs_pkg::CMD_NOP || cmd == sdcs_pkg::CMD_DESEL) begin
            next_mode = sdcs_pkg::MODE_PDOWN; // [R9]
          end else begin
            next_mode = sdcs_pkg::MODE_SUSPEND;
          end
        end
      end
      sdcs_pkg::MODE_SUSPEND: begin
        if (!clock_gate_prev && bus.clock_gate) begin // [R16]
          next_mode = sdcs_pkg::MODE_RUN; // [R17]
        end
      end
      sdcs_pkg::MODE_PDOWN, sdcs_pkg::MODE_SREF: begin
        if (!clock_gate_prev && bus.clock_gate) begin
          if (wake_ok) begin
            next_mode = sdcs_pkg::MODE_RUN; // [R8] [R9]
          end else begin
            next_proto_err = 1'b1; // [R8]
          end
        end
      end
    endcase

    next_burst_busy = (next_burst_left != '0);
    next_clk_run    = !((next_mode == sdcs_pkg::MODE_SUSPEND) && !next_clock_gate_prev);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      mode            <= sdcs_pkg::MODE_RUN;
      clock_gate_prev <= sdcs_pkg::RST_CLOCK_GATE;
      bank_open       <= '0;
      burst_left      <= '0;
      burst_bank      <= '0;
      burst_ap        <= 1'b0;
      burst_busy      <= 1'b0;
      clk_run         <= 1'b1;
      cmd_valid       <= 1'b0;
      cmd_q           <= sdcs_pkg::CMD_DESEL;
      cmd_bank        <= '0;
      cmd_ap          <= 1'b0;
      proto_err       <= 1'b0;
    end else begin
      mode            <= next_mode;
      clock_gate_prev <= next_clock_gate_prev;
      bank_open       <= next_bank_open;
      burst_left      <= next_burst_left;
      burst_bank      <= next_burst_bank;
      burst_ap        <= next_burst_ap;
      burst_busy      <= next_burst_busy;
      clk_run         <= next_clk_run;
      cmd_valid       <= next_cmd_valid;
      cmd_q           <= next_cmd_q;
      cmd_bank        <= next_cmd_bank;
      cmd_ap          <= next_cmd_ap;
      proto_err       <= next_proto_err;
    end
  end

  assign MODE       = mode;
  assign BANK_OPEN  = bank_open;
  assign BURST_BUSY = burst_busy;
  assign CLK_RUN    = clk_run;
  assign CMD_VALID  = cmd_valid;
  assign CMD        = cmd_q;
  assign CMD_BANK   = cmd_bank;
  assign CMD_AP     = cmd_ap;
  assign PROTO_ERR  = proto_err;

endmodule
`default_nettype wire

// File: hdl/sdcs_ctrl.sv
// Controller end: user requests to command pin levels
`timescale 1ns/1ns
`default_nettype none
module sdcs_ctrl #(
  parameter int BURST_LEN = 8,
  parameter bit FULL_PAGE = 1'b0
) (
  input  wire logic                      CLK,
  input  wire logic                      RST_N,
  sdcs_if.ctrl                           bus,
  input  wire logic                      REQ_VALID,
  input  wire sdcs_pkg::sdcs_op_t        REQ_OP,
  input  wire logic [sdcs_pkg::BANK_W-1:0] REQ_BANK,
  input  wire logic                      REQ_AP,
  output logic                           REQ_DONE,
  output logic                           REQ_REFUSED
);

  localparam int CNT_W = $clog2(BURST_LEN + 1);
  localparam logic [CNT_W-1:0] BL_LOAD = CNT_W'(BURST_LEN);
  localparam logic [CNT_W-1:0] ONE     = CNT_W'(1);

  ////////////////////////////////////////////////////////////////////////////
  // State

  sdcs_pkg::sdcs_mode_t            mode, next_mode;
  logic [3:0]                      pins, next_pins;
  logic                            gate, next_gate;
  logic [sdcs_pkg::BANK_W-1:0]     bs, next_bs;
  logic                            a10, next_a10;
  logic [sdcs_pkg::NUM_BANKS-1:0]  bank_open, next_bank_open;
  logic [CNT_W-1:0]                burst_left, next_burst_left;
  logic [sdcs_pkg::BANK_W-1:0]     burst_bank, next_burst_bank;
  logic                            burst_ap, next_burst_ap;
  logic                            done, next_done;
  logic                            refused, next_refused;
  logic                            ok;

  // {chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n}
  localparam logic [3:0] P_DESEL = 4'hf;
  localparam logic [3:0] P_NOP   = 4'h7;
  localparam logic [3:0] P_ACT   = 4'h3;
  localparam logic [3:0] P_READ  = 4'h5;
  localparam logic [3:0] P_WRITE = 4'h4;
  localparam logic [3:0] P_PRE   = 4'h2;
  localparam logic [3:0] P_MRS   = 4'h0;
  localparam logic [3:0] P_BST   = 4'h6;
  localparam logic [3:0] P_REF   = 4'h1;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_mode       = mode;
    next_gate       = gate; // [R12]
    next_bs         = REQ_BANK;
    next_a10        = REQ_AP;
    next_bank_open  = bank_open;
    next_burst_left = burst_left;
    next_burst_bank = burst_bank;
    next_burst_ap   = burst_ap;
    next_done       = 1'b0;
    next_refused    = 1'b0;
    ok              = 1'b0;
    // Idle pins: no-operation running, deselect asleep
    next_pins = (mode == sdcs_pkg::MODE_RUN) ? P_NOP : P_DESEL;

    // Mirror of the device burst, one edge ahead of it
    if (!(mode == sdcs_pkg::MODE_SUSPEND && !gate) && burst_left != '0 && !FULL_PAGE) begin
      next_burst_left = burst_left - ONE;
      if (burst_left == ONE && burst_ap) begin
        next_bank_open[burst_bank] = 1'b0;
      end
    end

    if (REQ_VALID) begin
      if (mode != sdcs_pkg::MODE_RUN) begin
        ok = (REQ_OP == sdcs_pkg::OP_WAKE);
        if (ok) begin
          next_gate = 1'b1; // [R8] [R9] [R17]
          next_mode = sdcs_pkg::MODE_RUN;
        end
      end else begin
        unique case (REQ_OP)
          sdcs_pkg::OP_NOP: ok = 1'b1;
          sdcs_pkg::OP_ACT: begin
            ok = !bank_open[REQ_BANK]; // [R3]
            next_pins = P_ACT;
            if (ok) next_bank_open[REQ_BANK] = 1'b1;
          end
          sdcs_pkg::OP_READ, sdcs_pkg::OP_WRITE: begin
            ok = bank_open[REQ_BANK] && !(FULL_PAGE && REQ_AP); // [R3]
            next_pins = (REQ_OP == sdcs_pkg::OP_READ) ? P_READ : P_WRITE; // [R2]
            if (ok) begin
              next_burst_left = BL_LOAD;
              next_burst_bank = REQ_BANK;
              next_burst_ap   = REQ_AP;
            end
          end
          sdcs_pkg::OP_PRE: begin
            ok = 1'b1;
            next_pins = P_PRE;
            next_a10  = 1'b0; // [R4]
            next_bank_open[REQ_BANK] = 1'b0;
            if (REQ_BANK == burst_bank) next_burst_left = '0;
          end
          sdcs_pkg::OP_PREALL: begin
            ok = 1'b1;
            next_pins = P_PRE;
            next_a10  = 1'b1; // [R4]
            next_bank_open  = '0;
            next_burst_left = '0;
          end
          sdcs_pkg::OP_MRS: begin
            ok = !(|bank_open); // [R3]
            next_pins = P_MRS;
          end
          sdcs_pkg::OP_BST: begin
            ok = FULL_PAGE && (burst_left != '0); // [R6]
            next_pins = P_BST;
            if (ok) next_burst_left = '0;
          end
          sdcs_pkg::OP_REF, sdcs_pkg::OP_SREF: begin
            ok = !(|bank_open); // [R7]
            next_pins = P_REF;
            if (ok && REQ_OP == sdcs_pkg::OP_SREF) begin
              next_gate = 1'b0;
              next_mode = sdcs_pkg::MODE_SREF;
            end
          end
          sdcs_pkg::OP_PDOWN: begin
            // Gate falling while busy means suspend
            ok = !(|bank_open) && burst_left == '0; // [R9] [R10]
            next_pins = P_DESEL;
            if (ok) begin
              next_gate = 1'b0;
              next_mode = sdcs_pkg::MODE_PDOWN;
            end
          end
          sdcs_pkg::OP_SUSPEND: begin
            ok = |bank_open; // [R13]
            if (ok) begin
              next_gate = 1'b0;
              next_mode = sdcs_pkg::MODE_SUSPEND;
            end
          end
          default: ok = 1'b0;
        endcase
      end
      if (!ok) begin
        next_pins = (mode == sdcs_pkg::MODE_RUN) ? P_NOP : P_DESEL;
      end
      next_done    = ok;
      next_refused = !ok;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      mode       <= sdcs_pkg::MODE_RUN;
      pins       <= P_DESEL;
      gate       <= sdcs_pkg::RST_CLOCK_GATE;
      bs         <= '0;
      a10        <= 1'b0;
      bank_open  <= '0;
      burst_left <= '0;
      burst_bank <= '0;
      burst_ap   <= 1'b0;
      done       <= 1'b0;
      refused    <= 1'b0;
    end else begin
      mode       <= next_mode;
      pins       <= next_pins;
      gate       <= next_gate;
      bs         <= next_bs;
      a10        <= next_a10;
      bank_open  <= next_bank_open;
      burst_left <= next_burst_left;
      burst_bank <= next_burst_bank;
      burst_ap   <= next_burst_ap;
      done       <= next_done;
      refused    <= next_refused;
    end
  end

  assign bus.chip_select_n      = pins[3];
  assign bus.row_strobe_n       = pins[2];
  assign bus.column_strobe_n    = pins[1];
  assign bus.write_strobe_n     = pins[0];
  assign bus.clock_gate         = gate;
  assign bus.bank_select_bits   = bs;
  assign bus.precharge_flag_bit = a10;
  assign REQ_DONE               = done;
  assign REQ_REFUSED            = refused;

endmodule
`default_nettype wire

// File: verification/sdcs_checker.sv
// Assertions on command pins and decoder outputs
`timescale 1ns/1ns
`default_nettype none
module sdcs_checker (
  input wire logic                 CLK,
  input wire logic                 RST_N,
  input wire logic                 chip_select_n,
  input wire logic                 row_strobe_n,
  input wire logic                 column_strobe_n,
  input wire logic                 write_strobe_n,
  input wire logic                 clock_gate,
  input wire logic [1:0]           bank_select_bits,
  input wire logic                 precharge_flag_bit,
  input wire sdcs_pkg::sdcs_mode_t MODE,
  input wire logic [3:0]           BANK_OPEN,
  input wire logic                 BURST_BUSY,
  input wire logic                 CLK_RUN,
  input wire logic                 CMD_VALID,
  input wire sdcs_pkg::sdcs_cmd_t  CMD
);
  // Previous gate level, reset high
  logic gp;
  always_ff @(posedge CLK) gp <= RST_N ? clock_gate : 1'b1;
  wire [2:0] s = {row_strobe_n, column_strobe_n, write_strobe_n};
  wire run = MODE == sdcs_pkg::MODE_RUN;
  wire sus = MODE == sdcs_pkg::MODE_SUSPEND;
  wire nap = MODE == sdcs_pkg::MODE_PDOWN || MODE == sdcs_pkg::MODE_SREF;
  wire go = run && gp && !chip_select_n;
  wire idle = BANK_OPEN == 4'h0 && !BURST_BUSY;
  wire fall = run && gp && !clock_gate;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  property p_cmd(logic [2:0] k, sdcs_pkg::sdcs_cmd_t c);
    go && s == k |=> CMD_VALID && CMD == c;
  endproperty
  ////////////////////////////////////////////////////////////////
  a_act_decode:
  assert property (p_cmd(3'h3, sdcs_pkg::CMD_ACT)) else $error("bad activate");
  a_read_decode:
  assert property (p_cmd(3'h5, sdcs_pkg::CMD_READ)) else $error("bad read");
  a_write_decode:
  assert property (p_cmd(3'h4, sdcs_pkg::CMD_WRITE)) else $error("bad write");
  a_mrs_decode:
  assert property (p_cmd(3'h0, sdcs_pkg::CMD_MRS)) else $error("bad mode set");
  a_pre_all:
  assert property (go && s == 3'h2 && precharge_flag_bit |=> BANK_OPEN == 4'h0)
    else $error("precharge all missed a bank");
  a_pre_one:
  assert property (go && s == 3'h2 && !precharge_flag_bit |=> !BANK_OPEN[$past(bank_select_bits)])
    else $error("bank not precharged");
  a_nop_quiet:
  assert property (run && (chip_select_n || s == 3'h7) |=> !CMD_VALID)
    else $error("idle command valid");
  a_auto_refresh:
  assert property (go && s == 3'h1 && clock_gate |=> CMD_VALID && CMD == sdcs_pkg::CMD_REF)
    else $error("bad refresh");
  a_sref_entry:
  assert property (go && s == 3'h1 && !clock_gate && idle |=> MODE == sdcs_pkg::MODE_SREF)
    else $error("no self refresh");
  a_pdown_entry:
  assert property (fall && idle && (chip_select_n || s == 3'h7) |=> MODE == sdcs_pkg::MODE_PDOWN)
    else $error("no power down");
  a_suspend_entry:
  assert property (fall && !idle |=> sus && !CLK_RUN) else $error("no suspend");
  a_suspend_frozen:
  assert property (sus |-> !CLK_RUN ##1 !CMD_VALID) else $error("suspended decoder ran");
  a_suspend_exit:
  assert property (sus && clock_gate |=> run && CLK_RUN) else $error("suspend not left");
  a_sleep_wake:
  assert property (nap && clock_gate && chip_select_n |=> run) else $error("sleep not left");
  c_suspend: cover property (sus ##1 run);
  c_sref: cover property (MODE == sdcs_pkg::MODE_SREF);
  c_pdown: cover property (MODE == sdcs_pkg::MODE_PDOWN);
endmodule
`default_nettype wire

// File: verification/tb.sv
// Bench joining the controller and decoder ends
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic                 clk;
  logic                 rst_n;
  logic                 req_valid;
  sdcs_pkg::sdcs_op_t   req_op;
  logic [1:0]           req_bank;
  logic                 req_ap;
  logic                 req_done;
  logic                 req_refused;
  sdcs_pkg::sdcs_mode_t mode;
  sdcs_pkg::sdcs_cmd_t  cmd;
  logic [3:0]           bank_open;
  logic [1:0]           cmd_bank;
  logic                 busy;
  logic                 clk_run;
  logic                 cmd_valid;
  logic                 cmd_ap;
  logic                 proto_err;
  int                   bad_count;
  int                   checks;
  sdcs_if bus ();
  sdcs_ctrl i_sdcs_ctrl (.CLK(clk), .RST_N(rst_n), .bus(bus), .REQ_VALID(req_valid),
    .REQ_OP(req_op), .REQ_BANK(req_bank), .REQ_AP(req_ap), .REQ_DONE(req_done),
    .REQ_REFUSED(req_refused));
  sdcs_device i_sdcs_device (.CLK(clk), .RST_N(rst_n), .bus(bus), .MODE(mode),
    .BANK_OPEN(bank_open), .BURST_BUSY(busy), .CLK_RUN(clk_run), .CMD_VALID(cmd_valid),
    .CMD(cmd), .CMD_BANK(cmd_bank), .CMD_AP(cmd_ap), .PROTO_ERR(proto_err));
  sdcs_checker i_sdcs_checker (.CLK(clk), .RST_N(rst_n), .chip_select_n(bus.chip_select_n),
    .row_strobe_n(bus.row_strobe_n), .column_strobe_n(bus.column_strobe_n),
    .write_strobe_n(bus.write_strobe_n), .clock_gate(bus.clock_gate),
    .bank_select_bits(bus.bank_select_bits), .precharge_flag_bit(bus.precharge_flag_bit),
    .MODE(mode), .BANK_OPEN(bank_open), .BURST_BUSY(busy), .CLK_RUN(clk_run),
    .CMD_VALID(cmd_valid), .CMD(cmd));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [3:0] e, input logic [3:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic req(input sdcs_pkg::sdcs_op_t op, input logic [1:0] b, input logic ap,
                     input logic ok);
    req_valid = 1'b1;
    req_op = op;
    req_bank = b;
    req_ap = ap;
    @(posedge clk);
    #1;
    chk("done", {3'h0, ok}, {3'h0, req_done});
    chk("refused", {3'h0, !ok}, {3'h0, req_refused});
  endtask
  task automatic wt(input int n);
    req_valid = 1'b0;
    repeat (n) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_access;
    req(sdcs_pkg::OP_ACT, 2'h1, 1'b0, 1'b1);
    chk("act pins", 4'h1, {bus.chip_select_n, bus.row_strobe_n, bus.bank_select_bits});
    req(sdcs_pkg::OP_READ, 2'h1, 1'b0, 1'b1);
    chk("cmd act", sdcs_pkg::CMD_ACT, cmd);
    chk("read pins", 4'h5, {bus.row_strobe_n, bus.column_strobe_n, bus.write_strobe_n});
    req(sdcs_pkg::OP_ACT, 2'h1, 1'b0, 1'b0);
    chk("cmd read", sdcs_pkg::CMD_READ, cmd);
    chk("busy", 4'h1, {3'h0, busy});
    req(sdcs_pkg::OP_WRITE, 2'h1, 1'b1, 1'b1);
    wt(1);
    chk("cmd write", sdcs_pkg::CMD_WRITE, cmd);
    chk("write ap", 4'h3, {2'h0, cmd_valid, cmd_ap});
    chk("write bank", 4'h1, {2'h0, cmd_bank});
    req(sdcs_pkg::OP_BST, 2'h0, 1'b0, 1'b0);
    for (int i = 0; i < 20 && busy !== 1'b0; i++) wt(1);
    chk("burst end", 4'h0, {3'h0, busy});
    chk("ap closed", 4'h0, bank_open);
  endtask
  task automatic t_pre;
    req(sdcs_pkg::OP_ACT, 2'h0, 1'b0, 1'b1);
    req(sdcs_pkg::OP_ACT, 2'h2, 1'b0, 1'b1);
    req(sdcs_pkg::OP_PRE, 2'h0, 1'b0, 1'b1);
    wt(1);
    chk("one bank", 4'h4, bank_open);
    req(sdcs_pkg::OP_PREALL, 2'h1, 1'b1, 1'b1);
    chk("all flag", 4'h1, {3'h0, bus.precharge_flag_bit});
    wt(1);
    chk("all banks", 4'h0, bank_open);
  endtask
  task automatic t_mrs_ref;
    req(sdcs_pkg::OP_MRS, 2'h0, 1'b0, 1'b1);
    wt(1);
    chk("cmd mrs", sdcs_pkg::CMD_MRS, cmd);
    req(sdcs_pkg::OP_REF, 2'h0, 1'b0, 1'b1);
    wt(1);
    chk("cmd ref", sdcs_pkg::CMD_REF, cmd);
    wt(1);
    chk("nop quiet", 4'h0, {3'h0, cmd_valid});
    req(sdcs_pkg::OP_ACT, 2'h0, 1'b0, 1'b1);
    req(sdcs_pkg::OP_MRS, 2'h0, 1'b0, 1'b0);
    req(sdcs_pkg::OP_PREALL, 2'h0, 1'b1, 1'b1);
  endtask
  task automatic t_sleep(input sdcs_pkg::sdcs_op_t op, input sdcs_pkg::sdcs_mode_t m);
    req(op, 2'h0, 1'b0, 1'b1);
    chk("gate low", 4'h0, {3'h0, bus.clock_gate});
    wt(1);
    chk("asleep", {2'h0, m}, {2'h0, mode});
    req(sdcs_pkg::OP_ACT, 2'h0, 1'b0, 1'b0);
    wt(3);
    chk("still asleep", {2'h0, m}, {2'h0, mode});
    req(sdcs_pkg::OP_WAKE, 2'h0, 1'b0, 1'b1);
    wt(1);
    chk("awake", {2'h0, sdcs_pkg::MODE_RUN}, {2'h0, mode});
  endtask
  task automatic t_suspend;
    req(sdcs_pkg::OP_ACT, 2'h3, 1'b0, 1'b1);
    req(sdcs_pkg::OP_READ, 2'h3, 1'b0, 1'b1);
    req(sdcs_pkg::OP_SUSPEND, 2'h0, 1'b0, 1'b1);
    wt(1);
    chk("suspended", {2'h0, sdcs_pkg::MODE_SUSPEND}, {2'h0, mode});
    chk("clock off", 4'h0, {3'h0, clk_run});
    wt(12);
    chk("frozen", 4'h1, {3'h0, busy});
    req(sdcs_pkg::OP_READ, 2'h3, 1'b0, 1'b0);
    req(sdcs_pkg::OP_WAKE, 2'h0, 1'b0, 1'b1);
    wt(1);
    chk("resumed", {2'h0, sdcs_pkg::MODE_RUN}, {2'h0, mode});
    chk("clock on", 4'h1, {3'h0, clk_run});
    wt(6);
    chk("burst tail", 4'h1, {3'h0, busy});
    wt(1);
    chk("burst done", 4'h0, {3'h0, busy});
    chk("bank kept", 4'h8, bank_open);
    chk("no error", 4'h0, {3'h0, proto_err});
  endtask
  task automatic complete_run;
    if (bad_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_op = sdcs_pkg::OP_NOP;
    req_bank = 2'h0;
    req_ap = 1'b0;
    bad_count = 0;
    checks = 0;
    repeat (12) @(posedge clk);
    #1;
    rst_n = 1'b1;
    chk("reset pins", 4'h3, {2'h0, bus.chip_select_n, bus.clock_gate});
    chk("reset mode", {2'h0, sdcs_pkg::MODE_RUN}, {2'h0, mode});
    t_access();
    t_pre();
    t_mrs_ref();
    t_sleep(sdcs_pkg::OP_SREF, sdcs_pkg::MODE_SREF);
    t_sleep(sdcs_pkg::OP_PDOWN, sdcs_pkg::MODE_PDOWN);
    t_suspend();
    complete_run();
  end
  // Tests need about 80 cycles
  initial begin
    repeat (3000) @(posedge clk);
    bad_count++;
    complete_run();
  end
endmodule
`default_nettype wire
